// file: rtl/seg_lcd_pkg.sv
package seg_lcd_pkg;
  // =========================================================
  // register map (word index on the plain port)
  localparam logic [5:0] CTRL_OFS     = 6'h00;
  localparam logic [5:0] PHASE_OFS    = 6'h01;
  localparam logic [5:0] ROLE_OFS     = 6'h02;
  localparam logic [5:0] PIXEL_OFS    = 6'h08;
  localparam logic [5:0] STATUS_OFS   = 6'h20;
  localparam int         ROLE_REGS    = 6;
  localparam int         PIXEL_REGS   = 24;
  // =========================================================
  // field positions
  localparam int CTRL_ON_POS    = 7;
  localparam int CTRL_SLEEP_POS = 6;
  localparam int CTRL_CS_POS    = 2;
  localparam int CTRL_MUX_POS   = 0;
  localparam int PH_TYPEB_POS   = 7;
  localparam int PH_BIAS_POS    = 4;
  localparam int PH_PRE_POS     = 0;
  // =========================================================
  // reset values
  localparam logic [7:0] CTRL_RST  = 8'h13;
  localparam logic [7:0] PHASE_RST = 8'h00;
  localparam logic [7:0] DATA_RST  = 8'h00;

  typedef enum logic [1:0] {MUX_STATIC, MUX_HALF, MUX_THIRD, MUX_QUARTER} mux_t;
  typedef enum logic [1:0] {BIAS_STATIC, BIAS_HALF, BIAS_THIRD, BIAS_RSVD} bias_t;

  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_t;

  // panel level: 0..3 in thirds of full drive
  typedef logic [1:0] level_t;
endpackage

// file: rtl/segment_lcd_driver.sv
// Overview of operation
// - static, half, third, quarter multiplex backplanes
// - frontplane count is 16, 24 or 42
// - bias static, half or third selectable
// - one of three clocks, then prescaler
// - 16-build quarter mux: shared pin is backplane
// - phase register: prescaler and waveform type
// - pin role bit: frontplane or port function
// - six pin role bytes, ascending groups
// - pixel bit one dark, zero clear
// - low pixel index: 3*backplane plus group
// - high pixel index: 12+3*backplane+group
// - 16-build lacks indices 2,5,8,11
// - module on bit starts and stops waveforms
// - sleep stop clear keeps running asleep
`timescale 1ns/1ps
`default_nettype none
module segment_lcd_driver #(
  parameter int SEGS = 24
) (
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire seg_lcd_pkg::bus_req_t bus,
  output logic [7:0]                 rdata,
  input  wire logic [2:0]            srcClk,
  input  wire logic                  sleeping,
  output logic [3:0][1:0]            backLevel,
  output logic [41:0][1:0]           frontLevel,
  output logic [41:0]                frontActive,
  output logic                       running
);
  import seg_lcd_pkg::*;

  // =========================================================
  // state
  typedef struct packed {
    logic [7:0]                   ctrl;
    logic [7:0]                   phase;
    logic [ROLE_REGS-1:0][7:0]    role;
    logic [PIXEL_REGS-1:0][7:0]   pixel;
    logic [7:0]                   rdata;
    logic [2:0][2:0]              sync;
    logic [3:0]                   preCnt;
    logic                         srcSeen;
    logic [1:0]                   bp;
    logic                         frame;
    logic [3:0][1:0]              back;
    logic [41:0][1:0]             front;
  } state_t;

  state_t stateReg;
  state_t stateNext;

  function automatic logic implemented(input logic [5:0] idx);
    logic ok;
    ok = 1'b1;
    if (idx >= ROLE_OFS && idx < ROLE_OFS + 6'(ROLE_REGS))
      ok = (idx - ROLE_OFS) < 6'((SEGS + 7) / 8);
    else if (idx >= PIXEL_OFS && idx < PIXEL_OFS + 6'(PIXEL_REGS)) begin
      if (SEGS <= 24 && (idx - PIXEL_OFS) >= 6'h0C)
        ok = 1'b0;
      if (SEGS == 16 && (idx - PIXEL_OFS) % 3 == 2)
        ok = 1'b0;
    end
    return ok;
  endfunction

  // pixel register index for segment s and backplane b
  function automatic int pixIdx(input int s, input int b);
    if (s < 24)
      return 3 * b + s / 8;
    return 12 + 3 * b + (s - 24) / 8;
  endfunction

  logic       srcLvl;
  logic       srcPrev;
  logic       tick;
  logic [1:0] muxSel;
  logic [1:0] biasSel;
  logic       typeB;
  logic       enabled;
  logic [1:0] lastBp;
  logic       bpDrive;
  logic       pix;
  logic       shared;
  logic [2:0] clkSel;

  always_comb begin
    stateNext = stateReg;
    bpDrive   = 1'b0;
    pix       = 1'b0;
    muxSel  = stateReg.ctrl[CTRL_MUX_POS +: 2];
    biasSel = stateReg.phase[PH_BIAS_POS +: 2];
    typeB   = stateReg.phase[PH_TYPEB_POS];
    // runs while the on bit is set, unless asleep with the sleep stop bit set
    enabled = stateReg.ctrl[CTRL_ON_POS]
            & ~(sleeping & stateReg.ctrl[CTRL_SLEEP_POS]);
    lastBp  = muxSel;
    shared  = (SEGS == 16) && (muxSel == MUX_QUARTER);
    clkSel  = 3'(stateReg.ctrl[CTRL_CS_POS +: 2]);

    // =========================================================
    // bus slave
    stateNext.rdata = 8'h00;
    if (bus.wr && implemented(bus.addr)) begin
      if (bus.addr == CTRL_OFS)
        stateNext.ctrl = bus.wdata;
      else if (bus.addr == PHASE_OFS)
        stateNext.phase = bus.wdata;
      else if (bus.addr >= ROLE_OFS && bus.addr < ROLE_OFS + 6'(ROLE_REGS))
        stateNext.role[3'(bus.addr - ROLE_OFS)] = bus.wdata;
      else if (bus.addr >= PIXEL_OFS && bus.addr < PIXEL_OFS + 6'(PIXEL_REGS))
        stateNext.pixel[5'(bus.addr - PIXEL_OFS)] = bus.wdata;
    end
    if (bus.rd && implemented(bus.addr)) begin
      if (bus.addr == CTRL_OFS)
        stateNext.rdata = stateReg.ctrl;
      else if (bus.addr == PHASE_OFS)
        stateNext.rdata = stateReg.phase;
      else if (bus.addr >= ROLE_OFS && bus.addr < ROLE_OFS + 6'(ROLE_REGS))
        stateNext.rdata = stateReg.role[3'(bus.addr - ROLE_OFS)];
      else if (bus.addr >= PIXEL_OFS && bus.addr < PIXEL_OFS + 6'(PIXEL_REGS))
        stateNext.rdata = stateReg.pixel[5'(bus.addr - PIXEL_OFS)];
      else if (bus.addr == STATUS_OFS)
        stateNext.rdata = {4'h0, enabled, stateReg.frame, stateReg.bp};
    end

    // =========================================================
    // clock source select and prescaler
    for (int i = 0; i < 3; i++)
      stateNext.sync[i] = {stateReg.sync[i][1:0], srcClk[i]};
    if (clkSel > 3'd2)
      clkSel = 3'd2;
    // a level counts only once the second and third stages agree
    srcLvl  = stateReg.sync[clkSel][2];
    srcPrev = stateReg.srcSeen;
    tick    = 1'b0;
    if (stateReg.sync[clkSel][1] == srcLvl)
      stateNext.srcSeen = srcLvl;
    if (srcLvl && stateReg.sync[clkSel][1] && !srcPrev) begin
      if (stateReg.preCnt >= stateReg.phase[PH_PRE_POS +: 4]) begin
        stateNext.preCnt = 4'h0;
        tick = 1'b1;
      end else
        stateNext.preCnt = stateReg.preCnt + 4'h1;
    end

    // =========================================================
    // phase sequencing: type A inverts within a phase pair,
    // type B inverts on alternate frames
    if (!enabled) begin
      stateNext.bp     = 2'd0;
      stateNext.frame  = 1'b0;
      stateNext.preCnt = 4'h0;
      stateNext.back   = '0;
      stateNext.front  = '0;
    end else if (tick) begin
      if (typeB) begin
        if (stateReg.bp >= lastBp) begin
          stateNext.bp    = 2'd0;
          stateNext.frame = ~stateReg.frame;
        end else
          stateNext.bp = stateReg.bp + 2'd1;
      end else begin
        stateNext.frame = ~stateReg.frame;
        if (stateReg.frame)
          stateNext.bp = (stateReg.bp >= lastBp) ? 2'd0 : stateReg.bp + 2'd1;
      end
      for (int b = 0; b < 4; b++) begin
        bpDrive = (2'(b) == stateNext.bp);
        if (2'(b) > lastBp)
          stateNext.back[b] = (biasSel == BIAS_THIRD) ? 2'd1 : 2'd1;
        else if (biasSel == BIAS_STATIC)
          stateNext.back[b] = stateNext.frame ? 2'd3 : 2'd0;
        else if (bpDrive)
          stateNext.back[b] = stateNext.frame ? 2'd3 : 2'd0;
        else if (biasSel == BIAS_HALF)
          stateNext.back[b] = 2'd1;
        else
          stateNext.back[b] = stateNext.frame ? 2'd1 : 2'd2;
      end
      for (int s = 0; s < 42; s++) begin
        pix = stateReg.pixel[pixIdx(s, int'(stateNext.bp))][s % 8];
        if (biasSel == BIAS_STATIC || biasSel == BIAS_HALF)
          stateNext.front[s] = (pix ^ stateNext.frame) ? 2'd3 : 2'd0;
        else if (pix)
          stateNext.front[s] = stateNext.frame ? 2'd0 : 2'd3;
        else
          stateNext.front[s] = stateNext.frame ? 2'd2 : 2'd1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stateReg       <= '0;
      stateReg.ctrl  <= CTRL_RST;
      stateReg.phase <= PHASE_RST;
    end else begin
      stateReg <= stateNext;
    end
  end

  // =========================================================
  // outputs
  always_comb begin
    rdata     = stateReg.rdata;
    running   = enabled;
    backLevel = stateReg.back;
    for (int s = 0; s < 42; s++) begin
      frontActive[s] = (s < SEGS) && stateReg.role[s / 8][s % 8];
      frontLevel[s]  = frontActive[s] ? stateReg.front[s] : 2'd0;
    end
    if (shared) begin
      frontActive[15] = 1'b0;
      frontLevel[15]  = 2'd0;
    end
  end

  // =========================================================
  // checks
  sequence offSeq;
    !stateReg.ctrl[CTRL_ON_POS];
  endsequence

  sequence stepSeq;
    enabled && tick && typeB && stateReg.bp < lastBp;
  endsequence

  sequence wrapSeq;
    enabled && tick && typeB && stateReg.bp >= lastBp;
  endsequence

  sequence holdSeq;
    enabled && !tick;
  endsequence

  sequence flipSeq;
    enabled && tick && !typeB;
  endsequence

  sequence staticSeq;
    enabled && tick && biasSel == BIAS_STATIC;
  endsequence

  sequence quarterSeq;
    enabled && tick && muxSel == MUX_QUARTER;
  endsequence

  // =========================================================
  // idle and storage checks
  idle_when_off_a: assert property (@(posedge clock) disable iff (!rst_n)
    offSeq |=> (stateReg.back == '0 && stateReg.front == '0))
    else $error("outputs not idle while off");
  keep_data_a: assert property (@(posedge clock) disable iff (!rst_n)
    (offSeq and !bus.wr) |=> $stable(stateReg.pixel))
    else $error("pixel lost while off");
  off_rewind_a: assert property (@(posedge clock) disable iff (!rst_n)
    !enabled |=> (stateReg.bp == 2'd0 && !stateReg.frame))
    else $error("phase not rewound while off");

  // =========================================================
  // register port checks
  read_ctrl_a: assert property (@(posedge clock) disable iff (!rst_n)
    (bus.rd && bus.addr == CTRL_OFS) |=> rdata == $past(stateReg.ctrl))
    else $error("control readback wrong");
  write_ctrl_a: assert property (@(posedge clock) disable iff (!rst_n)
    (bus.wr && bus.addr == CTRL_OFS) |=> stateReg.ctrl == $past(bus.wdata))
    else $error("control write lost");
  write_phase_a: assert property (@(posedge clock) disable iff (!rst_n)
    (bus.wr && bus.addr == PHASE_OFS) |=> stateReg.phase == $past(bus.wdata))
    else $error("phase write lost");
  write_role_a: assert property (@(posedge clock) disable iff (!rst_n)
    (bus.wr && bus.addr == ROLE_OFS) |=> stateReg.role[0] == $past(bus.wdata))
    else $error("pin role write lost");
  write_pixel_a: assert property (@(posedge clock) disable iff (!rst_n)
    (bus.wr && bus.addr == PIXEL_OFS) |=> stateReg.pixel[0] == $past(bus.wdata))
    else $error("pixel write lost");
  unimpl_read_a: assert property (@(posedge clock) disable iff (!rst_n)
    (bus.rd && !implemented(bus.addr)) |=> rdata == 8'h00)
    else $error("missing register read nonzero");

  // =========================================================
  // phase sequencing checks
  bp_in_range_a: assert property (@(posedge clock) disable iff (!rst_n)
    stateReg.bp <= stateReg.ctrl[1:0] || $changed(stateReg.ctrl))
    else $error("backplane phase beyond multiplex");
  bp_step_a: assert property (@(posedge clock) disable iff (!rst_n)
    stepSeq |=> stateReg.bp == $past(stateReg.bp) + 2'd1)
    else $error("backplane did not advance");
  bp_wrap_a: assert property (@(posedge clock) disable iff (!rst_n)
    wrapSeq |=> stateReg.bp == 2'd0)
    else $error("backplane did not wrap");
  frame_flip_a: assert property (@(posedge clock) disable iff (!rst_n)
    wrapSeq |=> stateReg.frame != $past(stateReg.frame))
    else $error("frame polarity not flipped");
  phase_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    holdSeq |=> ($stable(stateReg.bp) && $stable(stateReg.frame)))
    else $error("phase moved without tick");
  type_a_flip_a: assert property (@(posedge clock) disable iff (!rst_n)
    flipSeq |=> stateReg.frame != $past(stateReg.frame))
    else $error("polarity not flipped per tick");
  unused_back_a: assert property (@(posedge clock) disable iff (!rst_n)
    (enabled && tick && muxSel != MUX_QUARTER) |=> stateReg.back[3] == 2'd1)
    else $error("unused backplane level wrong");

  // =========================================================
  // bias and pixel checks
  static_back_a: assert property (@(posedge clock) disable iff (!rst_n)
    staticSeq |=> stateReg.back[0] == (stateReg.frame ? 2'd3 : 2'd0))
    else $error("static backplane level wrong");
  half_back_a: assert property (@(posedge clock) disable iff (!rst_n)
    (quarterSeq and biasSel == BIAS_HALF) |=> (stateReg.bp == 2'd3 || stateReg.back[3] == 2'd1))
    else $error("half bias idle level wrong");
  third_back_a: assert property (@(posedge clock) disable iff (!rst_n)
    (quarterSeq and biasSel == BIAS_THIRD)
      |=> (stateReg.bp == 2'd3 || stateReg.back[3] == (stateReg.frame ? 2'd1 : 2'd2)))
    else $error("third bias idle level wrong");
  static_pixel_a: assert property (@(posedge clock) disable iff (!rst_n)
    (staticSeq and muxSel == MUX_STATIC and stateReg.bp == 2'd0)
      |=> stateReg.front[0] == (($past(stateReg.pixel[0][0]) ^ stateReg.frame) ? 2'd3 : 2'd0))
    else $error("pixel drive wrong");

  // =========================================================
  // pin and sleep checks
  shared_pin_a: assert property (@(posedge clock) disable iff (!rst_n)
    shared |-> (!frontActive[15] && frontLevel[15] == 2'd0))
    else $error("shared pin used as frontplane");
  role_off_a: assert property (@(posedge clock) disable iff (!rst_n)
    !stateReg.role[0][0] |-> frontLevel[0] == 2'd0)
    else $error("port pin driven");
  seg_limit_a: assert property (@(posedge clock) disable iff (!rst_n)
    (SEGS < 42) |-> !frontActive[41])
    else $error("segment beyond build");
  small_build_a: assert property (@(posedge clock) disable iff (!rst_n)
    (SEGS == 16) |-> frontActive[23:16] == 8'h00)
    else $error("segment beyond small build");
  sleep_run_a: assert property (@(posedge clock) disable iff (!rst_n)
    (stateReg.ctrl[CTRL_ON_POS] && !stateReg.ctrl[CTRL_SLEEP_POS]) |-> running)
    else $error("stopped during sleep");
  sleep_stop_a: assert property (@(posedge clock) disable iff (!rst_n)
    (sleeping && stateReg.ctrl[CTRL_SLEEP_POS]) |-> !running)
    else $error("running while asleep");
endmodule // segment_lcd_driver
`default_nettype wire

// file: tb/lcd_panel_model.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_panel_model (
  input  wire logic            clock,
  input  wire logic            clear,
  input  wire logic [3:0][1:0] backLevel,
  input  wire logic [1:0]      frontLevel,
  output logic [3:0][1:0]      peak
);
  // ==========================================================
  // largest drive seen across each pixel of frontplane 0
  function automatic logic [1:0] gap(input logic [1:0] x, input logic [1:0] y);
    return (x > y) ? x - y : y - x;
  endfunction

  always_ff @(posedge clock) begin
    for (int b = 0; b < 4; b++) begin
      if (clear) begin
        peak[b] <= 2'h0;
      end else if (gap(backLevel[b], frontLevel) > peak[b]) begin
        peak[b] <= gap(backLevel[b], frontLevel); // full drive shows dark
      end
    end
  end
endmodule // lcd_panel_model
`default_nettype wire

// file: tb/segment_lcd_driver_test.sv
`timescale 1ns/1ps
`default_nettype none
module segment_lcd_driver_test;
  import seg_lcd_pkg::*;
  typedef struct packed {logic [5:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  logic             clock = 0;
  logic             rst_n = 0;
  logic             sleeping = 0;
  logic             clear = 1;
  bus_req_t         bus = '0;
  logic [7:0]       rdata;
  logic [2:0]       srcClk = '0;
  logic [3:0]       divCnt = '0;
  logic [3:0][1:0]  backLevel;
  logic [3:0][1:0]  peak;
  logic [41:0][1:0] frontLevel;
  logic [41:0]      frontActive;
  logic             running;
  int               n_mismatch = 0;
  int               checked = 0;
  int               cycles = 0;
  // unimplemented places of the 24 build must read 0
  row_t rows[8] = '{'{6'h01, 8'hA3, 8'hA3}, '{6'h02, 8'hFF, 8'hFF}, '{6'h04, 8'h5A, 8'h5A},
                    '{6'h05, 8'h77, 8'h00}, '{6'h08, 8'h81, 8'h81}, '{6'h13, 8'h3C, 8'h3C},
                    '{6'h14, 8'h0F, 8'h00}, '{6'h0B, 8'h00, 8'h00}};

  segment_lcd_driver #(.SEGS(24)) i_segment_lcd_driver (
    .clock(clock), .rst_n(rst_n), .bus(bus), .rdata(rdata), .srcClk(srcClk),
    .sleeping(sleeping), .backLevel(backLevel), .frontLevel(frontLevel),
    .frontActive(frontActive), .running(running));
  lcd_panel_model i_lcd_panel_model (
    .clock(clock), .clear(clear), .backLevel(backLevel), .frontLevel(frontLevel[0]),
    .peak(peak));

  // ==========================================================
  // clocks and timeout
  always #25 clock = ~clock;
  always @(posedge clock) begin
    divCnt <= divCnt + 4'h1;
    srcClk <= {divCnt[3], divCnt[2], divCnt[1]};
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch = n_mismatch + 1;
      tally_and_finish();
    end
  end

  // ==========================================================
  // tasks
  task check(input logic [7:0] seen, input logic [7:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    bus <= '0;
  endtask
  task rd_check(input logic [5:0] a, input logic [7:0] e);
    @(posedge clock);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock);
    bus <= '0;
    #1 check(rdata, e);
  endtask
  task settle(input int n);
    @(posedge clock);
    clear <= 1'b1;
    @(posedge clock);
    clear <= 1'b0;
    repeat (n) @(posedge clock);
    #1;
  endtask
  task tally_and_finish();
    $display("counts: %0d checks, %0d mismatches", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    rd_check(CTRL_OFS, CTRL_RST);
    rd_check(PHASE_OFS, PHASE_RST);
    rd_check(6'h3F, 8'h00);
    $display("test reset done");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd_check(rows[i].a, rows[i].e);
    end
    $display("test registers done");
    for (int m = 0; m < 3; m++) begin
      wr(CTRL_OFS, {6'h20, 2'(m)});
      settle(300);
      check({6'h00, backLevel[3]}, 8'h01);
    end
    wr(CTRL_OFS, 8'h83);
    settle(300);
    check({6'h00, peak[0]}, 8'h03);
    check({7'h00, peak[1] == 2'h3}, 8'h00);
    check(frontActive[7:0], 8'hFF);
    check(frontActive[23:16], 8'h5A);
    check({7'h00, frontActive[24]}, 8'h00);
    $display("test quarter multiplex done");
    wr(CTRL_OFS, 8'h8B);
    settle(700);
    check({6'h00, peak[0]}, 8'h03);
    $display("test clock source done");
    wr(PHASE_OFS, 8'h03);
    wr(CTRL_OFS, 8'h87);
    settle(300);
    check({6'h00, peak[0]}, 8'h03);
    $display("test type a static bias done");
    @(posedge clock);
    sleeping <= 1'b1;
    settle(5);
    check({7'h00, running}, 8'h01);
    wr(CTRL_OFS, 8'hC3);
    settle(5);
    check({7'h00, running}, 8'h00);
    @(posedge clock);
    sleeping <= 1'b0;
    $display("test sleep done");
    wr(CTRL_OFS, 8'h03);
    settle(100);
    check({7'h00, running}, 8'h00);
    check(backLevel, 8'h00);
    check({frontLevel[3], frontLevel[2], frontLevel[1], frontLevel[0]}, 8'h00);
    rd_check(PIXEL_OFS, 8'h81);
    rd_check(STATUS_OFS, 8'h00);
    $display("test disable done");
    tally_and_finish();
  end
endmodule // segment_lcd_driver_test
`default_nettype wire
